// ==== core/hbgc_gate_chan.sv ====
/*
 * One gate channel: cross-conduction on-delay and short latch.
 * Assumes the comparator input is already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none

module hbgc_gate_chan
    import hbgc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic active_i,
    hbgc_gate_if.chan g
);

    // Channel state held as one packed struct.
    typedef struct packed {
        logic [TMR_W-1:0] dly;
        logic [TMR_W-1:0] sc;
        logic on;
        logic latched;
    } hbgc_chan_type;

    hbgc_chan_type st;
    hbgc_chan_type next_st;

    // Next-state logic for delay, short timer and latch.
    always_comb begin
        next_st = st;
        if (!active_i) begin
            next_st = '{dly: TMR_RESET, sc: TMR_RESET, on: 1'b0, latched: 1'b0};
        end else begin
            // A control change drops the gate at the next clock edge and restarts the delay.
            if (g.changed || !g.demand) begin
                next_st.on = 1'b0;
                next_st.dly = TMR_RESET;
            end else if (!st.on) begin
                if (st.dly >= TMR_W'(XCOND_CYC - 1)) begin
                    next_st.on = 1'b1;
                end else begin
                    next_st.dly = st.dly + 1'b1;
                end
            end
            // Short timer counts while the gate is on and the node is wrong.
            if (st.on && g.bad_node && !st.latched) begin
                if (st.sc >= TMR_W'(SHORT_DETECT_CYC - 1)) begin
                    next_st.latched = 1'b1;
                end else begin
                    next_st.sc = st.sc + 1'b1;
                end
            end else begin
                next_st.sc = TMR_RESET;
            end
            // A control change, or the channel going inactive, releases the latch.
            if (g.changed) begin
                next_st.latched = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '{dly: TMR_RESET, sc: TMR_RESET, on: 1'b0, latched: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Latched transistor is kept off; others follow their demand.
    assign g.gate_on = st.on && !st.latched;
    assign g.shorted = st.latched;

    // A latched channel drives no gate.
    a_latch_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st.latched |-> !g.gate_on) else $error("latched gate still on");
    // Gate stays off for the two cycles after a change.
    a_ccp_delay: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        g.changed |=> !st.on [*2]) else $error("gate on too early");
    // Latch only after a full detection time of bad node.
    a_short_time: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(st.latched) |-> $past(st.sc) == TMR_W'(SHORT_DETECT_CYC - 1))
        else $error("short latched early");
    c_short: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(st.latched));

endmodule : hbgc_gate_chan

`default_nettype wire

// ==== core/hbgc_gate_if.sv ====
/*
 * Interface carrying one gate channel's demand, monitor and outputs.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface hbgc_gate_if;
    logic demand;    // Gate wanted on by the truth table.
    logic changed;   // One-cycle pulse: direction or PWM moved.
    logic bad_node;  // Synchronised comparator says node is wrong.
    logic gate_on;   // Resulting gate command.
    logic shorted;   // Level: this transistor is latched off.

    modport ctrl (output demand, output changed, output bad_node,
                  input gate_on, input shorted);
    modport chan (input demand, input changed, input bad_node,
                  output gate_on, output shorted);
endinterface : hbgc_gate_if

`default_nettype wire

// ==== core/hbgc_pkg.sv ====
/*
 * Shared constants and types for the H-bridge gate control logic.
 * Assumes a 250 MHz system clock; all timing counts derive from it.
 */
package hbgc_pkg;

    // System clock rate in MHz.
    localparam int CLK_MHZ = 250;

    // Shortest short-detection time in ns; a short is flagged after it.
    localparam int SHORT_DETECT_NS = 5000;

    // Short-detection time in cycles; a least time, so it rounds up.
    localparam int SHORT_DETECT_CYC = (SHORT_DETECT_NS * CLK_MHZ + 999) / 1000;

    // Cross-conduction delay in ns, typical figure of the on-delay.
    localparam int XCOND_NS = 1000;

    // Cross-conduction delay in cycles, rounded up.
    localparam int XCOND_CYC = (XCOND_NS * CLK_MHZ + 999) / 1000;

    // Recommended wake-up time in ns after enable rises.
    localparam int WAKE_NS = 50000;

    // Wake-up time in cycles; a least time, rounded up.
    localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;

    // Counter width for all timers.
    localparam int TMR_W = 16;

    // Reset value of a timer.
    localparam logic [TMR_W-1:0] TMR_RESET = 16'h0000;

    // Gate command bit positions in a four bit gate vector.
    localparam int GATE_HA = 0;
    localparam int GATE_LA = 1;
    localparam int GATE_HB = 2;
    localparam int GATE_LB = 3;

    // Gate vector reset value: all gates off.
    localparam logic [3:0] GATES_RESET = 4'h0;

    // Interrupt status bit positions.
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_SHORT = 1;
    localparam int IRQ_ENABLE = 2;

    // Register offsets of the software port.
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_STAT = 4'h4;
    localparam logic [3:0] REG_IRQ_MASK = 4'h8;

    // Reset value of the three bit interrupt registers.
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Operating mode of the bridge.
    typedef enum logic [1:0] {
        HBGC_STANDBY,
        HBGC_ACTIVE,
        HBGC_FAULT
    } hbgc_mode_type;

endpackage : hbgc_pkg

// ==== core/hbgc_top.sv ====
/*
 * Top of the H-bridge gate control logic: input synchronisers,
 * truth table decode, fault forcing, diagnostic and register port.
 * Assumes fault flags and node comparators arrive asynchronously,
 * and that external pull-ups are modelled by the tristate enables.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Gates follow inputs only while enabled.
// - Enable low: standby, gates resistive, diagnostic tristate.
// - Undriven direction and PWM read high.
// - Decode direction and PWM per truth table.
// - Overtemperature sinks gates, kills line, diagnostic low.
// - Overvoltage sinks gates, kills line, diagnostic low.
// - Undervoltage keeps gates sunk, diagnostic low.
// - Shorted high side latched off until change.
// - Shorted low side latched off until change.
// - Only shorted transistors switch off.
// - Diagnostic low on any shutdown, else high.
// - Input change cuts gate, delayed turn-on.
module hbgc_top
    import hbgc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic dir_i,
    input wire logic dir_driven_i,
    input wire logic pwm_i,
    input wire logic pwm_driven_i,
    input wire logic overtemp_flag_i,
    input wire logic supply_high_flag_i,
    input wire logic supply_low_flag_i,
    input wire logic bridge_node_a_low_i,
    input wire logic bridge_node_b_low_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [3:0] gate_on_o,
    output logic [3:0] gate_sink_o,
    output logic gates_resistive_o,
    output logic fault_indicator_n_o,
    output logic fault_indicator_n_oe_o,
    output logic line_off_o,
    output logic awake_o,
    output logic irq_o
);

    // Raw asynchronous inputs gathered for the synchronisers.
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;

    // Undriven direction and PWM default high, as internal pull-ups do.
    assign raw_in = {bridge_node_b_low_i, bridge_node_a_low_i, supply_low_flag_i,
                     supply_high_flag_i, overtemp_flag_i,
                     pwm_i | !pwm_driven_i, dir_i | !dir_driven_i, enable_i};

    // Two-stage synchronisers; only stage two feeds logic.
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                // Direction and PWM idle high, so they reset high: no false change.
                if (rst_i) begin
                    sync1[gi] <= 1'(gi == 1 || gi == 2);
                    sync2[gi] <= 1'(gi == 1 || gi == 2);
                end else begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    // Named views of the synchronised inputs.
    logic en_s;
    logic dir_s;
    logic pwm_s;
    logic fault_s;
    logic node_a_low;
    logic node_b_low;
    assign en_s = sync2[0];
    assign dir_s = sync2[1];
    assign pwm_s = sync2[2];
    assign fault_s = sync2[3] | sync2[4] | sync2[5];
    assign node_a_low = sync2[6];
    assign node_b_low = sync2[7];

    // Top state held as one packed struct.
    typedef struct packed {
        hbgc_mode_type mode;
        logic dir_q;
        logic pwm_q;
        logic [TMR_W-1:0] wake;
        logic awake;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] rdata;
    } hbgc_top_type;

    hbgc_top_type st;
    hbgc_top_type next_st;

    // Channel interfaces and their outputs.
    hbgc_gate_if gif [4] ();
    logic [3:0] demand;
    logic [3:0] bad_node;
    logic [3:0] chan_on;
    logic [3:0] chan_short;
    logic ctrl_change;
    logic active;
    logic any_short;
    logic shutdown;

    // A move of direction or PWM is seen against last cycle's value.
    assign ctrl_change = (dir_s != st.dir_q) || (pwm_s != st.pwm_q);
    assign active = (st.mode != HBGC_STANDBY) && en_s;

    // Truth table: braking on PWM high, else direction picks diagonal.
    always_comb begin
        demand = GATES_RESET;
        if (pwm_s) begin
            demand[GATE_HA] = 1'b1;
            demand[GATE_HB] = 1'b1;
        end else if (dir_s) begin
            demand[GATE_HA] = 1'b1;
            demand[GATE_LB] = 1'b1;
        end else begin
            demand[GATE_LA] = 1'b1;
            demand[GATE_HB] = 1'b1;
        end
    end

    // High side wrong when its node stays low; low side when it stays high.
    assign bad_node[GATE_HA] = node_a_low;
    assign bad_node[GATE_HB] = node_b_low;
    assign bad_node[GATE_LA] = !node_a_low;
    assign bad_node[GATE_LB] = !node_b_low;

    // One channel per gate, each with its own delay and short latch.
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            assign gif[gi].demand = demand[gi];
            assign gif[gi].changed = ctrl_change;
            assign gif[gi].bad_node = bad_node[gi];
            assign chan_on[gi] = gif[gi].gate_on;
            assign chan_short[gi] = gif[gi].shorted;
            hbgc_gate_chan u_chan (
                .sys_clk_i(sys_clk_i),
                .rst_i(rst_i),
                .active_i(active && !fault_s),
                .g(gif[gi])
            );
        end
    endgenerate

    assign any_short = |chan_short;
    assign shutdown = fault_s || any_short;

    // Mode, wake timer, interrupt registers and read port.
    always_comb begin
        next_st = st;
        next_st.dir_q = dir_s;
        next_st.pwm_q = pwm_s;
        next_st.rdata = 32'h0000_0000;
        // Standby whenever enable is low, whatever else happens.
        if (!en_s) begin
            next_st.mode = HBGC_STANDBY;
            next_st.wake = TMR_RESET;
            next_st.awake = 1'b0;
        end else begin
            next_st.mode = fault_s ? HBGC_FAULT : HBGC_ACTIVE;
            if (!st.awake) begin
                if (st.wake >= TMR_W'(WAKE_CYC - 1)) begin
                    next_st.awake = 1'b1;
                end else begin
                    next_st.wake = st.wake + 1'b1;
                end
            end
        end
        // Write one clears; a new event in the same cycle wins.
        if (wr_i && addr_i == REG_IRQ_STAT) begin
            next_st.irq_stat = st.irq_stat & ~wdata_i[2:0];
        end
        if (wr_i && addr_i == REG_IRQ_MASK) begin
            next_st.irq_mask = wdata_i[2:0];
        end
        if (active && fault_s) begin
            next_st.irq_stat[IRQ_FAULT] = 1'b1;
        end
        if (active && any_short) begin
            next_st.irq_stat[IRQ_SHORT] = 1'b1;
        end
        if (en_s && !st.awake && next_st.awake) begin
            next_st.irq_stat[IRQ_ENABLE] = 1'b1;
        end
        // Read data stand the cycle after the strobe; unmapped reads zero.
        if (rd_i) begin
            case (addr_i)
                REG_STATUS: next_st.rdata = {24'h00_0000, chan_short, any_short,
                                             fault_s, st.awake, active};
                REG_IRQ_STAT: next_st.rdata = {29'h0000_0000, st.irq_stat};
                REG_IRQ_MASK: next_st.rdata = {29'h0000_0000, st.irq_mask};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '{mode: HBGC_STANDBY, dir_q: 1'b1, pwm_q: 1'b1, wake: TMR_RESET,
                    awake: 1'b0, irq_stat: IRQ_RESET, irq_mask: IRQ_RESET,
                    rdata: 32'h0000_0000};
        end else begin
            st <= next_st;
        end
    end

    // Gate outputs: resistive in standby, sunk on fault, else per channel.
    always_comb begin
        if (!active) begin
            gate_on_o = GATES_RESET;
            gate_sink_o = GATES_RESET;
            gates_resistive_o = 1'b1;
        end else if (fault_s) begin
            gate_on_o = GATES_RESET;
            gate_sink_o = 4'hF;
            gates_resistive_o = 1'b0;
        end else begin
            gate_on_o = chan_on;
            gate_sink_o = ~chan_on;
            gates_resistive_o = 1'b0;
        end
    end

    // Diagnostic is open drain: driven low on shutdown, released otherwise.
    assign fault_indicator_n_o = 1'b0;
    assign fault_indicator_n_oe_o = active && shutdown;
    assign line_off_o = active && (sync2[3] || sync2[4]);
    assign awake_o = st.awake;
    assign rdata_o = st.rdata;
    assign irq_o = |(st.irq_stat & st.irq_mask);

    // Any fault sinks all four gates.
    a_fault_sink: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (active && fault_s) |-> (gate_sink_o == 4'hF && gate_on_o == 4'h0))
        else $error("gates not sunk on fault");
    // Standby leaves gates resistive and diagnostic released.
    a_standby_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !en_s |=> (gates_resistive_o && !fault_indicator_n_oe_o))
        else $error("standby not resistive");
    // Diagnostic pulled exactly while a shutdown is in force.
    a_diag_level: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        active |-> (fault_indicator_n_oe_o == (fault_s || any_short)))
        else $error("diagnostic mismatch");
    // Braking never drives a low side.
    a_brake_decode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (pwm_s && st.pwm_q) |-> (!gate_on_o[GATE_LA] && !gate_on_o[GATE_LB]))
        else $error("low side on in braking");
    // No gate on in the cycle after a control change.
    a_change_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ctrl_change |=> gate_on_o == 4'h0) else $error("gate on after change");
    // A latched high side b short persists while inputs are steady.
    a_short_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (active && !fault_s && chan_short[GATE_HB] && !ctrl_change) |=>
        chan_short[GATE_HB] || !active || fault_s)
        else $error("short released without change");
    // Overvoltage turns the line off.
    a_line_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (active && sync2[4]) |-> line_off_o) else $error("line not off");
    // Pin high when undriven reaches logic two cycles later.
    a_pullup: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!dir_driven_i ##2 1'b1) |-> dir_s) else $error("pull-up lost");
    c_brake: cover property (@(posedge sys_clk_i) disable iff (rst_i) active && pwm_s);
    c_fault: cover property (@(posedge sys_clk_i) disable iff (rst_i) active && fault_s);
    c_irq: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(irq_o));

endmodule : hbgc_top

`default_nettype wire

// ==== testbench/hbgc_host_model.sv ====
/*
 * Behavioural host that drives enable, direction and PWM pins.
 * Assumes the bench calls its tasks right after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module hbgc_host_model
    import hbgc_pkg::*;
(
    input wire logic sys_clk_i,
    output logic enable_o,
    output logic dir_o,
    output logic dir_driven_o,
    output logic pwm_o,
    output logic pwm_driven_o
);
    // The host starts with enable low and both pins driven high.
    initial begin
        enable_o = 1'b0;
        dir_o = 1'b1;
        pwm_o = 1'b1;
        dir_driven_o = 1'b1;
        pwm_driven_o = 1'b1;
    end

    // Drives both control pins to the given levels.
    task automatic drive(input logic d, input logic p);
        @(posedge sys_clk_i);
        dir_o <= d;
        pwm_o <= p;
        dir_driven_o <= 1'b1;
        pwm_driven_o <= 1'b1;
    endtask : drive

    // Lets go of both pins; the wire shows the inverse of the last driven level, so only the pull-up decides.
    task automatic release_pins();
        @(posedge sys_clk_i);
        dir_o <= ~dir_o;
        pwm_o <= ~pwm_o;
        dir_driven_o <= 1'b0;
        pwm_driven_o <= 1'b0;
    endtask : release_pins

    // Raises enable with both pins high, then waits for the supplies.
    task automatic wake();
        drive(1'b1, 1'b1);
        @(posedge sys_clk_i);
        enable_o <= 1'b1;
        repeat (WAKE_CYC + 8) @(posedge sys_clk_i);
    endtask : wake

    // Puts both pins high before enable is lowered.
    task automatic sleep();
        drive(1'b1, 1'b1);
        @(posedge sys_clk_i);
        enable_o <= 1'b0;
    endtask : sleep
endmodule : hbgc_host_model

`default_nettype wire

// ==== testbench/hbgc_test.sv ====
/*
 * Self-checking bench for the H-bridge gate control top.
 * Assumes the host model file and the core files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module hbgc_test;
    import hbgc_pkg::*;
    logic sys_clk_i = 1'b0; // System clock, 4 ns period.
    logic rst_i = 1'b1; // Reset, held for four cycles.
    logic ot = 1'b0, ov = 1'b0, uv = 1'b0; // Fault flag levels.
    logic na = 1'b0, nb = 1'b0; // Node-below-threshold comparators.
    logic [3:0] addr = 4'h0; // Register address.
    logic [31:0] wdata = 32'h0000_0000; // Register write data.
    logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0; // Strobes and delayed read.
    logic en, dir, dir_dr, pwm, pwm_dr, res, oe, loff, awake, irq;
    logic [3:0] on, snk; // Gate source and sink commands.
    logic [31:0] rdata; // Read data.
    logic [23:0] gate_q[$]; // Notes of {mask, value} for the outputs.
    logic [31:0] rd_q[$]; // Notes of expected read data.
    logic aw_q[$]; // Notes of the expected wake indication.
    logic [1:0] tbl[5] = '{2'h0, 2'h2, 2'h1, 2'h3, 2'h0}; // {dir, pwm} steps.
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;

    // The clock toggles every half period.
    always #2 sys_clk_i = ~sys_clk_i;

    hbgc_host_model host (.sys_clk_i(sys_clk_i), .enable_o(en), .dir_o(dir),
        .dir_driven_o(dir_dr), .pwm_o(pwm), .pwm_driven_o(pwm_dr));

    hbgc_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .enable_i(en), .dir_i(dir),
        .dir_driven_i(dir_dr), .pwm_i(pwm), .pwm_driven_i(pwm_dr),
        .overtemp_flag_i(ot), .supply_high_flag_i(ov), .supply_low_flag_i(uv),
        .bridge_node_a_low_i(na), .bridge_node_b_low_i(nb), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .gate_on_o(on),
        .gate_sink_o(snk), .gates_resistive_o(res), .fault_indicator_n_o(),
        .fault_indicator_n_oe_o(oe), .line_off_o(loff), .awake_o(awake), .irq_o(irq));

    // Gates wanted on for a pin pair: bit 0 high a, 1 low a, 2 high b, 3 low b.
    function automatic logic [3:0] gate_of(input logic d, input logic p);
        return p ? 4'h5 : (d ? 4'h9 : 4'h6);
    endfunction : gate_of

    // Compares the output vector under a mask with the oldest note.
    task automatic cmp_gate(input logic [23:0] e);
        num_checks++;
        if (({irq, loff, oe, res, snk, on} & e[23:12]) !== (e[11:0] & e[23:12])) begin
            n_mismatch++;
            $display("[ERR] %0t outputs %h want %h", $time, {irq, loff, oe, res, snk, on}, e);
        end
    endtask : cmp_gate

    // Compares read data with the oldest read note.
    task automatic cmp_rd(input logic [31:0] e);
        num_checks++;
        if (rdata !== e) begin
            n_mismatch++;
            $display("[ERR] %0t read %h want %h", $time, rdata, e);
        end
    endtask : cmp_rd

    // Compares the wake indication with the oldest wake note.
    task automatic cmp_awake(input logic e);
        num_checks++;
        if (awake !== e) begin
            n_mismatch++;
            $display("[ERR] %0t awake %b want %b", $time, awake, e);
        end
    endtask : cmp_awake

    // The watcher compares outputs at the falling edge, once they have settled.
    always @(negedge sys_clk_i) begin
        while (gate_q.size() > 0) cmp_gate(gate_q.pop_front());
        while (aw_q.size() > 0) cmp_awake(aw_q.pop_front());
        if (rd_d === 1'b1) cmp_rd(rd_q.pop_front());
    end

    // Read data stand in the cycle after the strobe.
    always @(posedge sys_clk_i) begin
        rd_d <= rd;
    end

    // Cuts a hung run short.
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    end

    // Notes an output expectation {irq, line, oe, resistive, sink, on}.
    task automatic expect_out(input logic [11:0] v, input logic [11:0] m);
        gate_q.push_back({m, v});
    endtask : expect_out

    // One read cycle with its expected data.
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge sys_clk_i);
        rd <= 1'b0;
    endtask : rd_reg

    // One write cycle, then two cycles for the effect to land.
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask : wr_reg

    // Sets the pins and puts both nodes where no short is seen.
    task automatic set_io(input logic d, input logic p);
        logic [3:0] g;
        g = gate_of(d, p);
        host.drive(d, p);
        na <= ~g[0];
        nb <= ~g[2];
    endtask : set_io

    // Prints the verdict and ends the run.
    task automatic results();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // Main sequence.
    initial begin
        logic [3:0] g;
        void'($urandom(32'h6a7b));
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // Standby ignores random pin levels.
        repeat (6) begin
            host.drive(1'($urandom), 1'($urandom));
            repeat (4) @(posedge sys_clk_i);
            expect_out(12'h100, 12'hFFF);
        end
        rd_reg(REG_STATUS, 32'h0000_0000);
        aw_q.push_back(1'b0);
        host.wake();
        aw_q.push_back(1'b1);
        rd_reg(REG_STATUS, 32'h0000_0003);
        rd_reg(REG_IRQ_STAT, 32'h0000_0004);
        rd_reg(REG_IRQ_MASK, 32'h0000_0000);
        rd_reg(4'hC, 32'h0000_0000);
        wr_reg(REG_IRQ_MASK, 32'h0000_0007);
        expect_out(12'h800, 12'h800);
        wr_reg(REG_IRQ_STAT, 32'h0000_0004);
        expect_out(12'h000, 12'h800);
        wr_reg(4'hC, 32'hFFFF_FFFF);
        rd_reg(REG_IRQ_MASK, 32'h0000_0007);
        // Every pin pair, each step a change.
        for (int i = 0; i < 5; i++) begin
            g = gate_of(tbl[i][1], tbl[i][0]);
            set_io(tbl[i][1], tbl[i][0]);
            repeat (6) @(posedge sys_clk_i);
            expect_out(12'h000, 12'h60F);
            repeat (200) @(posedge sys_clk_i);
            expect_out(12'h000, 12'h00F);
            repeat (60) @(posedge sys_clk_i);
            expect_out({4'h0, ~g, g}, 12'h7FF);
        end
        // Released pins read high, which means braking.
        host.release_pins();
        na <= 1'b0;
        nb <= 1'b0;
        repeat (270) @(posedge sys_clk_i);
        expect_out(12'h0A5, 12'h7FF);
        host.drive(1'b1, 1'b1);
        // Each fault flag in turn.
        for (int i = 0; i < 3; i++) begin
            {ot, ov, uv} <= 3'h4 >> i;
            repeat (6) @(posedge sys_clk_i);
            expect_out({1'b1, 1'(i < 2), 2'h2, 4'hF, 4'h0}, 12'hFFF);
            {ot, ov, uv} <= 3'h0;
            repeat (270) @(posedge sys_clk_i);
            expect_out(12'h0A5, 12'h7FF);
        end
        rd_reg(REG_IRQ_STAT, 32'h0000_0001);
        wr_reg(REG_IRQ_MASK, 32'h0000_0000);
        expect_out(12'h000, 12'h800);
        wr_reg(REG_IRQ_MASK, 32'h0000_0007);
        expect_out(12'h800, 12'h800);
        wr_reg(REG_IRQ_STAT, 32'h0000_0001);
        expect_out(12'h000, 12'h800);
        // High side b held on with its node low.
        set_io(1'b0, 1'b0);
        nb <= 1'b1;
        repeat (266) @(posedge sys_clk_i);
        expect_out(12'h006, 12'h60F);
        repeat (1180) @(posedge sys_clk_i);
        expect_out(12'h006, 12'h60F);
        repeat (100) @(posedge sys_clk_i);
        expect_out(12'hA02, 12'hE0F);
        rd_reg(REG_STATUS, 32'h0000_004B);
        // A pin change frees the latch; low side b then sees its node high.
        set_io(1'b1, 1'b0);
        nb <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        expect_out(12'h000, 12'h200);
        repeat (260) @(posedge sys_clk_i);
        expect_out(12'h009, 12'h60F);
        repeat (1300) @(posedge sys_clk_i);
        expect_out(12'h201, 12'h60F);
        rd_reg(REG_STATUS, 32'h0000_008B);
        host.sleep();
        repeat (6) @(posedge sys_clk_i);
        expect_out(12'h100, 12'h7FF);
        aw_q.push_back(1'b0);
        repeat (2) @(posedge sys_clk_i);
        results();
    end
endmodule : hbgc_test

`default_nettype wire
